// ==== design/cis_sequencer.v ====
// interrupt entry/return sequencer of an 8-bit core
// assumes the core reports instruction boundaries and opcode strobes as one-cycle pulses
// How it works
// - core clock is clk_i directly; no divider anywhere
// - register operation completes in one cycle; sequencer never stalls it
// - take a source only when its enable and global enable are both set
// - suppress interrupts per PC region when either lock bit pair is programmed
// - vectors at lowest addresses; lower address means higher priority
// - table select bit moves vectors to boot section start
// - boot reset fuse moves reset vector to boot section start
// - accepting an interrupt clears global enable
// - software may set global enable inside handler, allowing nesting
// - flag sources lose their flag when vectored
// - writing one to a flag bit clears it
// - flags set while disabled stay until enabled and served or cleared
// - requests pending while global enable low are served by priority later
// - level sources request only while their condition is present
// - after return, one instruction runs before next interrupt
// - status register is neither saved nor restored by hardware
// - clear-enable instruction masks immediately, even same-cycle requests
// - after set-enable instruction, next instruction runs first
// - entry takes four cycles and pushes the program counter
// - vector jump takes three cycles
// - multi-cycle instruction finishes before an interrupt is served
// - wake from sleep adds four cycles beyond start-up time
// - return takes four cycles, pops PC, SP plus two, sets enable
// - entry push decrements stack pointer by two
// - global enable lives in bit 7 of the status register
`timescale 1ns/10ps
`default_nettype none
`include "cis_map.vh"

module cis_sequencer (
  input  wire                  clk_i,          // core clock
  input  wire                  reset_n_i,      // async reset, active low
  input  wire [`CIS_NSRC-1:0]  src_event_i,    // flag-type condition pulses
  input  wire [`CIS_NSRC-1:0]  src_level_i,    // level-type conditions
  input  wire [`CIS_NSRC-1:0]  src_is_level_i, // 1: source is level type
  input  wire [`CIS_NSRC-1:0]  src_enable_i,   // individual enables
  input  wire [`CIS_NSRC-1:0]  flag_clear_i,   // write-one-to-clear strobe
  input  wire                  insn_done_i,    // instruction boundary pulse
  input  wire                  op_set_gie_i,   // set-enable instruction pulse
  input  wire                  op_clr_gie_i,   // clear-enable instruction pulse
  input  wire                  op_return_from_handler_op_i,      // return_from_handler_op pulse
  input  wire                  core_status_register_wr_i,      // software write of status reg
  input  wire [7:0]            core_status_register_wdata_i,   // status write data
  input  wire [7:0]            alu_flags_i,    // low flags from alu, bits 6..0
  input  wire                  alu_flags_we_i, // alu updates flags
  input  wire                  sleeping_i,     // core in sleep mode
  input  wire                  wake_ready_i,   // sleep start-up time elapsed
  input  wire [`CIS_PC_W-1:0]  pc_i,           // current program counter
  input  wire [`CIS_PC_W-1:0]  boot_start_i,   // boot section start word
  input  wire                  vector_table_select_i, // core_control_register bit
  input  wire                  boot_reset_fuse_i,     // programmed: reset in boot
  input  wire                  app_lock_bit_b_i,      // programmed lock, app side
  input  wire                  boot_lock_bit_b_i,     // programmed lock, boot side
  input  wire [15:0]           pop_data_i,     // return address from stack
  output reg  [7:0]            core_status_register_o,         // core_status_register
  output reg  [`CIS_SP_W-1:0]  sp_o,           // stack pointer
  output reg                   push_o,         // pushing return address
  output reg  [15:0]           push_data_o,    // return address to push
  output reg                   pop_o,          // popping return address
  output reg                   pc_load_o,      // load pc_target_o
  output reg  [`CIS_PC_W-1:0]  pc_target_o,    // vector or return address
  output reg                   core_stall_o,   // hold the fetch unit
  output reg  [`CIS_NSRC-1:0]  flag_o,         // latched flags
  output reg  [2:0]            active_src_o    // last vectored source
);

  ////////////////////////////////////////////////////////////////////////////
  // timing, counted in edges from the one that samples a take or a return:
  //   edge 0  take; push_o, sp minus two and global enable low one cycle later
  //   edge 4  vector loaded on pc_load_o, or edge 8 when the core was asleep
  //   edge 7  stall drops after the three jump cycles (edge 11 after a wake)
  //   return  pop_o one cycle after the strobe; pc, sp and enable at edge 4
  // the stack partner must present the popped word by edge 4 of a return
  // the wake count sees sleeping_i one cycle late, so a core that enters
  // sleep on the very edge of the take is timed as a normal entry
  // lock suppression only looks at pc_i, so the core must present the pc
  // of the instruction that ends at the boundary
  // a flag event in the same cycle as its clear or its vectoring wins,
  // so a condition that recurs during entry is served again later
  // level sources keep no flag; enable and condition must both still
  // stand at the boundary edge
  // pc_target_o keeps its last value between loads
  // hold_ff is the one-instruction shadow after set-enable and return

  localparam ST_RUN   = 2'h0;
  localparam ST_ENTRY = 2'h1;
  localparam ST_RET   = 2'h2;
  localparam ST_JUMP  = 2'h3;

  reg        rst_s1_ff;
  reg        rst_s2_ff;
  wire       rst_n;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0]            state_ff;
  reg [1:0]            nxt_state;
  reg [2:0]            cnt_ff;
  reg [2:0]            nxt_cnt;
  reg                  hold_ff;     // one-instruction shadow after sei/return_from_handler_op
  reg                  nxt_hold;
  reg                  woke_ff;
  reg [`CIS_PC_W-1:0]  ret_pc_ff;
  reg                  started_ff;
  reg [7:0]            nxt_core_status_register;
  reg [`CIS_SP_W-1:0]  nxt_sp;
  reg [`CIS_NSRC-1:0]  nxt_flag;
  wire [`CIS_NSRC-1:0] req;
  wire [`CIS_NSRC-1:0] grant;
  wire [2:0]           win_idx;
  wire                 win_any;
  wire                 gie;
  wire                 lock_block;
  wire                 take;
  // decodes used only by the output logic
  wire [`CIS_PC_W-1:0] vec_addr;
  wire                 entry_last;
  wire                 ret_last;

  // vector base: boot section or zero
  function [`CIS_PC_W-1:0] cis_base;
    input sel;
    input [`CIS_PC_W-1:0] boot;
    begin
      cis_base = sel ? boot : `CIS_RESET_VEC;
    end
  endfunction

  assign gie = core_status_register_o[`CIS_GIE_BIT];

  assign lock_block = (app_lock_bit_b_i && (pc_i <  boot_start_i)) ||
                      (boot_lock_bit_b_i && (pc_i >= boot_start_i));

  genvar g;
  generate
    for (g = 0; g < `CIS_NSRC; g = g + 1) begin : g_req
      assign req[g] = src_enable_i[g] &
                      (src_is_level_i[g] ? src_level_i[g] : flag_o[g]);
    end
  endgenerate

  cis_prio_pick u_pick (
    .req_i   (req),
    .grant_o (grant),
    .idx_o   (win_idx),
    .any_o   (win_any)
  );

  // take only at a boundary or on a ready wake from sleep, clear-enable masks same cycle
  assign take = (state_ff == ST_RUN) && win_any && gie && !op_clr_gie_i &&
                !hold_ff && !lock_block &&
                (insn_done_i || (sleeping_i && wake_ready_i));

  // table base, first source one step above reset, one step per index
  assign vec_addr = cis_base(vector_table_select_i, boot_start_i) + `CIS_VEC_FIRST +
                    ({{(`CIS_PC_W-3){1'b0}}, win_idx} * `CIS_VEC_STEP);

  // last counted cycle of an entry or a return
  assign entry_last = (state_ff == ST_ENTRY) && (cnt_ff == 3'h0);
  assign ret_last   = (state_ff == ST_RET) && (cnt_ff == 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_hold  = hold_ff;
    nxt_core_status_register  = core_status_register_o;
    nxt_sp    = sp_o;
    // event sets win over any clear
    nxt_flag  = (flag_o & ~flag_clear_i) | src_event_i;
    // only alu and software change status bits 6..0
    if (alu_flags_we_i)
      nxt_core_status_register[6:0] = alu_flags_i[6:0];
    if (core_status_register_wr_i)
      nxt_core_status_register = core_status_register_wdata_i;
    if (insn_done_i && state_ff == ST_RUN)
      nxt_hold = 1'b0;
    case (state_ff)
      ST_RUN: begin
        if (op_clr_gie_i)
          nxt_core_status_register[`CIS_GIE_BIT] = 1'b0;
        if (op_set_gie_i) begin
          nxt_core_status_register[`CIS_GIE_BIT] = 1'b1;
          nxt_hold = 1'b1;
        end
        if (op_return_from_handler_op_i) begin
          nxt_state = ST_RET;
          nxt_cnt   = `CIS_RET_CYC - 3'h1;
        end else if (take) begin
          nxt_core_status_register[`CIS_GIE_BIT] = 1'b0;
          nxt_flag = nxt_flag & ~(grant & ~src_is_level_i & ~src_event_i);
          nxt_state = ST_ENTRY;
          nxt_cnt = woke_ff ? (`CIS_ENTRY_CYC + `CIS_WAKE_CYC - 3'h1) :
                              (`CIS_ENTRY_CYC - 3'h1);
          nxt_sp = sp_o - `CIS_SP_STEP;
        end
      end
      ST_ENTRY: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h0) begin
          nxt_state = ST_JUMP;
          nxt_cnt   = `CIS_JMP_CYC - 3'h1;
        end
      end
      ST_JUMP: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h0)
          nxt_state = ST_RUN;
      end
      ST_RET: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h0) begin
          // pop, sp plus two, enable, one-instruction shadow
          nxt_state = ST_RUN;
          nxt_sp    = sp_o + `CIS_SP_STEP;
          nxt_core_status_register[`CIS_GIE_BIT] = 1'b1;
          nxt_hold  = 1'b1;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // every register on clk_i, undivided; no stall outside sequences
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= ST_RUN;
      cnt_ff       <= 3'h0;
      hold_ff      <= 1'b0;
      woke_ff      <= 1'b0;
      ret_pc_ff    <= `CIS_RESET_VEC;
      started_ff   <= 1'b0;
      core_status_register_o       <= `CIS_CORE_STATUS_REGISTER_RESET;
      sp_o         <= `CIS_SP_RESET;
      flag_o       <= {`CIS_NSRC{1'b0}};
      push_o       <= 1'b0;
      push_data_o  <= 16'h0000;
      pop_o        <= 1'b0;
      pc_load_o    <= 1'b0;
      pc_target_o  <= `CIS_RESET_VEC;
      core_stall_o <= 1'b0;
      active_src_o <= 3'h0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      hold_ff    <= nxt_hold;
      core_status_register_o     <= nxt_core_status_register;
      sp_o       <= nxt_sp;
      flag_o     <= nxt_flag;
      woke_ff    <= sleeping_i;
      started_ff <= 1'b1;
      push_o     <= take;
      pop_o      <= (state_ff == ST_RUN) && op_return_from_handler_op_i;
      pc_load_o  <= 1'b0;
      core_stall_o <= (nxt_state != ST_RUN);
      if (!started_ff) begin
        pc_load_o   <= 1'b1;
        pc_target_o <= cis_base(boot_reset_fuse_i, boot_start_i);
      end else if (take) begin
        push_data_o  <= {{(16-`CIS_PC_W){1'b0}}, pc_i};
        active_src_o <= win_idx;
        // vector held until the entry count runs out
        ret_pc_ff <= vec_addr;
      end else if (entry_last) begin
        pc_load_o   <= 1'b1;
        pc_target_o <= ret_pc_ff;
      end else if (ret_last) begin
        pc_load_o   <= 1'b1;
        pc_target_o <= pop_data_i[`CIS_PC_W-1:0];
      end
    end
  end

endmodule // cis_sequencer
`default_nettype wire

// ==== inc/cis_map.vh ====
// constants for the core interrupt sequencer: vectors, status bits, cycle counts
// assumes a 13-bit word program counter and a 16-bit byte stack pointer
`ifndef CIS_MAP_VH
`define CIS_MAP_VH

`define CIS_NSRC          8
`define CIS_PC_W          13
`define CIS_SP_W          16
`define CIS_GIE_BIT       7
`define CIS_VEC_STEP      13'h0002
`define CIS_VEC_FIRST     13'h0002
`define CIS_RESET_VEC     13'h0000
`define CIS_ENTRY_CYC     3'h4
`define CIS_WAKE_CYC      3'h4
`define CIS_RET_CYC       3'h4
`define CIS_JMP_CYC       3'h3
`define CIS_SP_STEP       16'h0002
`define CIS_SP_RESET      16'h0000
`define CIS_CORE_STATUS_REGISTER_RESET    8'h00

`endif

// ==== design/cis_prio_pick.v ====
// fixed-priority picker: lowest source index (lowest vector address) wins
// assumes the request vector is already gated by enables
`timescale 1ns/10ps
`default_nettype none
`include "cis_map.vh"

module cis_prio_pick (
  input  wire [`CIS_NSRC-1:0] req_i,    // gated requests
  output reg  [`CIS_NSRC-1:0] grant_o,  // one-hot winner
  output reg  [2:0]           idx_o,    // winner index
  output reg                  any_o     // some request present
);
  integer i;
  always @* begin
    grant_o = {`CIS_NSRC{1'b0}};
    idx_o   = 3'h0;
    any_o   = 1'b0;
    for (i = `CIS_NSRC-1; i >= 0; i = i - 1) begin
      if (req_i[i]) begin
        grant_o = {`CIS_NSRC{1'b0}};
        grant_o[i] = 1'b1;
        idx_o   = i[2:0];
        any_o   = 1'b1;
      end
    end
  end
endmodule // cis_prio_pick
`default_nettype wire

// ==== dv/cis_seq_asserts.sv ====
// timing checker for the interrupt sequencer ports
// assumes it is bound onto cis_sequencer and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module cis_seq_asserts (
  input wire logic        clk_i,        // core clock
  input wire logic        reset_n_i,    // reset, active low
  input wire logic        insn_done_i,  // instruction boundary
  input wire logic        sleeping_i,   // core asleep
  input wire logic        op_clr_gie_i, // clear-enable strobe
  input wire logic [7:0]  core_status_register_o,       // status
  input wire logic [15:0] sp_o,         // stack pointer
  input wire logic        push_o,       // push strobe
  input wire logic        pop_o,        // pop strobe
  input wire logic        pc_load_o,    // pc load strobe
  input wire logic        core_stall_o  // fetch hold
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  // push shows one cycle after the take; upper bound 8 covers the wake-up extension
  a_entry_vector: assert property (push_o |-> ##[4:8] pc_load_o)
    else $error("vector load missing after push");
  a_push_sp: assert property (push_o |-> sp_o == $past(sp_o) - 16'h0002)
    else $error("stack pointer not lowered by two");
  a_push_gie: assert property (push_o |-> !core_status_register_o[7])
    else $error("global enable still set after entry");
  a_take_gie: assert property (push_o |-> $past(core_status_register_o[7]))
    else $error("entry taken with global enable low");
  a_take_edge: assert property (push_o |-> $past(insn_done_i || sleeping_i))
    else $error("entry taken inside an instruction");
  a_jump_stall: assert property (push_o |-> core_stall_o [*6])
    else $error("stall dropped before jump finished");
  a_clr_mask: assert property (op_clr_gie_i |=> !push_o && !core_status_register_o[7])
    else $error("entry after clear-enable");
  a_ret_load: assert property (pop_o |-> ##4 (pc_load_o && core_status_register_o[7] &&
    sp_o == $past(sp_o, 4) + 16'h0002))
    else $error("return sequence wrong");
endmodule // cis_seq_asserts
`default_nettype wire

// ==== dv/cis_stack_model.sv ====
// stack partner: keeps pushed return addresses and answers pops
// assumes one-cycle push and pop strobes from the sequencer
`timescale 1ns/10ps
`default_nettype none
module cis_stack_model (
  input  wire logic        clk_i,    // core clock
  input  wire logic        push_i,   // push strobe
  input  wire logic [15:0] push_d_i, // pushed address
  input  wire logic        pop_i,    // pop strobe
  output logic [15:0]      pop_d_o   // top or popped address
);
  logic [15:0] mem [0:3];
  logic [1:0]  top_ff;
  logic [15:0] hold_ff;
  logic        pend_ff;
  initial begin
    top_ff = 2'h0;
    pend_ff = 1'b0;
    hold_ff = 16'h5a5a;
    for (int i = 0; i < 4; i++) mem[i] = 16'ha5a5;
  end
  // popped value is held, so a late sampler still sees the right word
  assign pop_d_o = pend_ff ? hold_ff : mem[top_ff - 2'h1];
  always @(posedge clk_i) begin
    if (push_i) begin
      mem[top_ff] <= push_d_i;
      top_ff <= top_ff + 2'h1;
      pend_ff <= 1'b0;
    end else if (pop_i) begin
      hold_ff <= mem[top_ff - 2'h1];
      top_ff <= top_ff - 2'h1;
      pend_ff <= 1'b1;
    end
  end
endmodule // cis_stack_model
`default_nettype wire

// ==== dv/test_cpu_interrupt_sequencer.sv ====
// self-checking bench for the interrupt sequencer
// assumes cis_stack_model as stack partner; boot section at word 0x1000
`timescale 1ns/10ps
`default_nettype none
module test_cpu_interrupt_sequencer;
  logic        clk_i, reset_n_i, core_status_register_wr_i, alu_flags_we_i, sleeping_i, wake_ready_i;
  logic        vector_table_select_i, boot_reset_fuse_i, app_lock_bit_b_i, boot_lock_bit_b_i;
  logic        push_o, pop_o, pc_load_o, core_stall_o;
  logic [7:0]  src_event_i, src_level_i, src_is_level_i, src_enable_i, flag_clear_i;
  logic [7:0]  core_status_register_wdata_i, alu_flags_i, core_status_register_o, flag_o;
  logic [12:0] pc_i, boot_start_i, pc_target_o;
  logic [15:0] sp_o, push_data_o, pop_data_i;
  logic [2:0]  active_src_o;
  logic [3:0]  ops;
  int          n_errors, checks;
  wire logic   insn_done_i = ops[0];
  wire logic   op_set_gie_i = ops[1];
  wire logic   op_clr_gie_i = ops[2];
  wire logic   op_return_from_handler_op_i = ops[3];
  cis_sequencer dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .src_event_i(src_event_i),
    .src_level_i(src_level_i), .src_is_level_i(src_is_level_i), .src_enable_i(src_enable_i),
    .flag_clear_i(flag_clear_i), .insn_done_i(insn_done_i), .op_set_gie_i(op_set_gie_i),
    .op_clr_gie_i(op_clr_gie_i), .op_return_from_handler_op_i(op_return_from_handler_op_i), .core_status_register_wr_i(core_status_register_wr_i),
    .core_status_register_wdata_i(core_status_register_wdata_i), .alu_flags_i(alu_flags_i), .alu_flags_we_i(alu_flags_we_i),
    .sleeping_i(sleeping_i), .wake_ready_i(wake_ready_i), .pc_i(pc_i),
    .boot_start_i(boot_start_i), .vector_table_select_i(vector_table_select_i),
    .boot_reset_fuse_i(boot_reset_fuse_i), .app_lock_bit_b_i(app_lock_bit_b_i),
    .boot_lock_bit_b_i(boot_lock_bit_b_i), .pop_data_i(pop_data_i), .core_status_register_o(core_status_register_o),
    .sp_o(sp_o), .push_o(push_o), .push_data_o(push_data_o), .pop_o(pop_o),
    .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .core_stall_o(core_stall_o),
    .flag_o(flag_o), .active_src_o(active_src_o));
  cis_stack_model stk_u (.clk_i(clk_i), .push_i(push_o), .push_d_i(push_data_o),
    .pop_i(pop_o), .pop_d_o(pop_data_i));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes bits: 0 boundary, 1 set-enable, 2 clear-enable, 3 return
  task automatic op(input logic [3:0] v, input logic [12:0] pc);
    ops = v;
    pc_i = pc;
    @(negedge clk_i);
    ops = 4'h0;
  endtask
  task automatic wait_load(input logic [15:0] exp);
    for (int i = 0; i < 20 && pc_load_o !== 1'b1; i++) @(negedge clk_i);
    chk(pc_load_o, 1'b1);
    chk(pc_target_o, exp);
    for (int i = 0; i < 20 && core_stall_o !== 1'b0; i++) @(negedge clk_i);
    chk(core_stall_o, 1'b0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_entry;
    src_enable_i = 8'h24;
    src_event_i = 8'h24;
    @(negedge clk_i);
    src_event_i = 8'h00;
    chk(flag_o, 8'h24);
    op(4'h2, 13'h0040);
    op(4'h1, 13'h0041);
    chk(push_o, 1'b0);
    op(4'h1, 13'h0123);
    chk(push_o, 1'b1);
    chk(push_data_o, 16'h0123);
    chk(sp_o, 16'hfffe);
    chk(core_status_register_o[7], 1'b0);
    chk(flag_o, 8'h20);
    chk(active_src_o, 16'h0002);
    chk(core_stall_o, 1'b1);
    wait_load(16'h1006);
    alu_flags_i = 8'h15;
    alu_flags_we_i = 1'b1;
    @(negedge clk_i);
    alu_flags_we_i = 1'b0;
    op(4'h8, 13'h1006);
    chk(pop_o, 1'b1);
    wait_load(16'h0123);
    chk(core_status_register_o, 8'h95);
    chk(sp_o, 16'h0000);
    op(4'h1, 13'h0123);
    chk(push_o, 1'b0);
    op(4'h1, 13'h0124);
    chk(push_o, 1'b1);
    chk(active_src_o, 16'h0005);
    wait_load(16'h100c);
    $display("test entry and return done");
  endtask
  task automatic t_mask;
    src_enable_i = 8'h00;
    core_status_register_wdata_i = 8'h80;
    core_status_register_wr_i = 1'b1;
    src_event_i = 8'h04;
    @(negedge clk_i);
    core_status_register_wr_i = 1'b0;
    src_event_i = 8'h00;
    op(4'h1, 13'h0200);
    chk(push_o, 1'b0);
    chk(flag_o, 8'h04);
    src_enable_i = 8'h04;
    op(4'h5, 13'h0201);
    chk(push_o, 1'b0);
    chk(core_status_register_o[7], 1'b0);
    flag_clear_i = 8'h04;
    @(negedge clk_i);
    flag_clear_i = 8'h00;
    chk(flag_o, 8'h00);
    $display("test masking done");
  endtask
  task automatic t_level;
    src_is_level_i = 8'h08;
    src_enable_i = 8'h00;
    src_level_i = 8'h08;
    @(negedge clk_i);
    src_level_i = 8'h00;
    src_enable_i = 8'h08;
    op(4'h2, 13'h0300);
    op(4'h1, 13'h0301);
    op(4'h1, 13'h0302);
    chk(push_o, 1'b0);
    src_level_i = 8'h08;
    op(4'h1, 13'h0303);
    chk(push_o, 1'b1);
    repeat (3) @(negedge clk_i);
    chk(pc_load_o, 1'b0);
    wait_load(16'h1008);
    $display("test level source done");
  endtask
  task automatic t_reset;
    reset_n_i = 1'b0;
    boot_reset_fuse_i = 1'b0;
    {src_level_i, src_is_level_i, src_enable_i} = 24'h00_0000;
    repeat (2) @(negedge clk_i);
    chk(sp_o, 16'h0000);
    chk(core_status_register_o, 16'h0000);
    reset_n_i = 1'b1;
    wait_load(16'h0000);
    $display("test reset vector done");
  endtask
  task automatic t_sleep;
    op(4'h2, 13'h0400);
    op(4'h1, 13'h0401);
    {sleeping_i, wake_ready_i} = 2'h3;
    src_enable_i = 8'h01;
    src_event_i = 8'h01;
    @(negedge clk_i);
    src_event_i = 8'h00;
    @(negedge clk_i);
    {sleeping_i, wake_ready_i} = 2'h0;
    chk(push_o, 1'b1);
    repeat (7) @(negedge clk_i);
    chk(pc_load_o, 1'b0);
    wait_load(16'h1002);
    $display("test sleep wake done");
  endtask
  task automatic t_lock;
    {app_lock_bit_b_i, vector_table_select_i} = 2'h2;
    src_enable_i = 8'h02;
    src_event_i = 8'h02;
    core_status_register_wdata_i = 8'h80;
    core_status_register_wr_i = 1'b1;
    @(negedge clk_i);
    {src_event_i, core_status_register_wr_i} = 9'h000;
    op(4'h1, 13'h0200);
    chk(push_o, 1'b0);
    op(4'h1, 13'h1200);
    chk(push_o, 1'b1);
    wait_load(16'h0004);
    $display("test lock and table base done");
  endtask
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // the whole sequence needs well under 300 cycles
  initial begin
    #4000;
    n_errors++;
    conclude();
  end
  initial begin
    {reset_n_i, core_status_register_wr_i, alu_flags_we_i, sleeping_i, wake_ready_i} = 5'h00;
    {app_lock_bit_b_i, boot_lock_bit_b_i, ops, pc_i} = 19'h0_0000;
    {src_event_i, src_level_i, src_is_level_i, src_enable_i} = 32'h0000_0000;
    {flag_clear_i, core_status_register_wdata_i, alu_flags_i} = 24'h00_0000;
    {vector_table_select_i, boot_reset_fuse_i} = 2'h3;
    boot_start_i = 13'h1000;
    n_errors = 0;
    checks = 0;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    wait_load(16'h1000);
    chk(core_status_register_o, 8'h00);
    t_entry();
    t_mask();
    t_level();
    t_reset();
    t_sleep();
    t_lock();
    conclude();
  end
endmodule // test_cpu_interrupt_sequencer
bind cis_sequencer cis_seq_asserts chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .insn_done_i(insn_done_i), .sleeping_i(sleeping_i), .op_clr_gie_i(op_clr_gie_i),
  .core_status_register_o(core_status_register_o), .sp_o(sp_o), .push_o(push_o), .pop_o(pop_o), .pc_load_o(pc_load_o),
  .core_stall_o(core_stall_o));
`default_nettype wire
